/* File: mmcr_pkg.sv */
// Purpose: Shared constants and types for the motion machine control register bank
// Assumes: Classic Wishbone slave, 32-bit data, one register per aligned word
// Notes: Register index times four gives the byte address
package mmcr_pkg;

    localparam int MMCR_MACHINES = 16;
    localparam int MMCR_ADDR_W = 10;

    // Register indices
    localparam logic [7:0] IDX_PAGE_SEL = 8'h02;
    localparam logic [7:0] IDX_STATUS_LOW = 8'h13;
    localparam logic [7:0] IDX_STATUS_HIGH = 8'h14;
    localparam logic [7:0] IDX_PAGE_ACCESS = 8'h17;
    localparam logic [7:0] IDX_BATCH_CFG = 8'h44;
    localparam logic [7:0] IDX_ENABLE_LOW = 8'h46;
    localparam logic [7:0] IDX_ENABLE_HIGH = 8'h47;
    localparam logic [7:0] IDX_COUNT_LOW = 8'h48;
    localparam logic [7:0] IDX_COUNT_HIGH = 8'h49;
    localparam logic [7:0] IDX_CLEAR_CTRL = 8'h4A;
    localparam logic [7:0] IDX_PAGE_DATA = 8'h50;
    localparam logic [7:0] IDX_IRQ_STATUS = 8'h60;
    localparam logic [7:0] IDX_IRQ_MASK = 8'h61;

    // Field positions
    localparam int PAGE_SEL_LSB = 0;
    localparam int PAGE_SEL_W = 4;
    localparam int BIT_LATCH_MODE = 7;
    localparam int BIT_PAGE_WRITE = 6;
    localparam int BIT_PAGE_READ = 5;
    localparam int BIT_BATCH_EN = 6;
    localparam int BIT_CLEAR_CMD = 0;
    localparam int BIT_CLEAR_DONE = 1;

    // Interrupt status bit layout
    localparam int IRQ_W = 4;
    localparam int IRQ_MACH_LOW = 0;
    localparam int IRQ_MACH_HIGH = 1;
    localparam int IRQ_CLEAR_DONE = 2;
    localparam int IRQ_BATCH = 3;

    // Reset values
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [15:0] RST_COUNT = 16'h0000;
    localparam logic [IRQ_W-1:0] RST_IRQ = 4'h0;

    typedef enum logic [1:0] {
        LC_IDLE = 2'b00,
        LONG_COUNT_CLEAR_BIT = 2'b01,
        LC_DONE = 2'b11
    } mmcr_lc_state_t;

    typedef struct packed {
        logic [MMCR_MACHINES-1:0] machine_enable;
        logic step_count_batch_enable;
        logic embedded_irq_latch_mode;
        logic page_write_enable;
        logic page_read_enable;
        logic [PAGE_SEL_W-1:0] page_select;
    } mmcr_cfg_t;

    typedef struct packed {
        logic valid;
        logic [PAGE_SEL_W-1:0] page;
        logic [7:0] data;
    } mmcr_page_wr_t;

endpackage

/* File: mmcr_regs.sv */
// Purpose: Register bank for sixteen programmable motion state machines
// Assumes: Events, ticks and step values come from logic on clk_i
// Notes: Wishbone classic slave, byte address = register index * 4
`timescale 1ns/1ps
module mmcr_regs
    import mmcr_pkg::*;
#(
    parameter int MACHINES = MMCR_MACHINES
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [MMCR_ADDR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic [MACHINES-1:0] machine_event_i,
    input wire logic long_count_tick_i,
    input wire logic step_count_valid_i,
    input wire logic [15:0] step_count_i,
    input wire logic [7:0] page_rdata_i,
    output mmcr_cfg_t cfg_o,
    output mmcr_page_wr_t page_wr_o,
    output logic page_rd_o,
    output logic fifo_wr_o,
    output logic [15:0] fifo_data_o,
    output logic irq_o
);

    // Configuration registers
    logic [PAGE_SEL_W-1:0] page_select;
    logic embedded_irq_latch_mode;
    logic page_write_enable;
    logic page_read_enable;
    logic step_count_batch_enable;
    logic [7:0] machine_enable_low;
    logic [7:0] machine_enable_high;
    logic long_count_clear_cmd;
    logic long_count_clear_done;
    logic [15:0] long_count;
    logic [15:0] machine_status;
    mmcr_lc_state_t lc_state;
    logic [IRQ_W-1:0] irq_status;
    logic [IRQ_W-1:0] irq_mask;
    logic [IRQ_W-1:0] irq_event;
    logic [MACHINES-1:0] gated_event;
    logic [MACHINES-1:0] status_rd_clr;
    logic [MACHINES-1:0] machine_enable;
    logic clear_active;
    logic irq_pending;

    // Bus decode
    logic bus_req;
    logic wr_stb;
    logic rd_stb;
    logic [7:0] reg_idx;
    logic [7:0] wr_byte;
    logic [31:0] next_rdata;

    function automatic logic hit(input logic [7:0] idx, input logic [7:0] target);
        hit = (idx == target);
    endfunction

    // One access per request; ack drops in the cycle after it rose
    assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign wr_stb = bus_req && wb_we_i && wb_sel_i[0];
    assign rd_stb = bus_req && !wb_we_i;
    // Indices past the map land on an unused slot and read zero
    assign reg_idx = (wb_adr_i[MMCR_ADDR_W-1:2] < 256) ? 8'(wb_adr_i[MMCR_ADDR_W-1:2]) : 8'hFF;
    assign wr_byte = wb_dat_i[7:0];

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= bus_req;
        end
    end

    // Page selector and access control
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            page_select <= RST_BYTE[PAGE_SEL_W-1:0];
        end else if (wr_stb && hit(reg_idx, IDX_PAGE_SEL)) begin
            page_select <= wr_byte[PAGE_SEL_LSB +: PAGE_SEL_W];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            embedded_irq_latch_mode <= 1'b0;
            page_write_enable <= 1'b0;
            page_read_enable <= 1'b0;
        end else if (wr_stb && hit(reg_idx, IDX_PAGE_ACCESS)) begin
            // Reserved low bits are not stored
            embedded_irq_latch_mode <= wr_byte[BIT_LATCH_MODE];
            page_write_enable <= wr_byte[BIT_PAGE_WRITE];
            page_read_enable <= wr_byte[BIT_PAGE_READ];
        end
    end

    // Batching configuration
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            step_count_batch_enable <= 1'b0;
        end else if (wr_stb && hit(reg_idx, IDX_BATCH_CFG)) begin
            step_count_batch_enable <= wr_byte[BIT_BATCH_EN];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            fifo_wr_o <= 1'b0;
            fifo_data_o <= RST_COUNT;
        end else begin
            fifo_wr_o <= step_count_batch_enable && step_count_valid_i;
            if (step_count_batch_enable && step_count_valid_i) begin
                fifo_data_o <= step_count_i;
            end
        end
    end

    // Machine enables
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            machine_enable_low <= RST_BYTE;
            machine_enable_high <= RST_BYTE;
        end else if (wr_stb) begin
            if (hit(reg_idx, IDX_ENABLE_LOW)) begin
                machine_enable_low <= wr_byte;
            end
            if (hit(reg_idx, IDX_ENABLE_HIGH)) begin
                machine_enable_high <= wr_byte;
            end
        end
    end

    // Disabled machines cannot raise status
    assign machine_enable = MACHINES'({machine_enable_high, machine_enable_low});
    assign gated_event = machine_event_i & machine_enable;

    // Status bits: read of a byte clears its latched bits, a new event wins
    generate
        for (genvar g = 0; g < MACHINES; g++) begin : g_status
            assign status_rd_clr[g] = rd_stb && hit(reg_idx, (g < 8) ? IDX_STATUS_LOW : IDX_STATUS_HIGH);
            always_ff @(posedge clk_i) begin
                if (rst_i) begin
                    machine_status[g] <= 1'b0;
                end else if (!embedded_irq_latch_mode) begin
                    machine_status[g] <= gated_event[g];
                end else if (gated_event[g]) begin
                    machine_status[g] <= 1'b1;
                end else if (status_rd_clr[g]) begin
                    machine_status[g] <= 1'b0;
                end
            end
        end
    endgenerate

    // Long counter clear sequence
    // Done rises at the same edge as the zeroing, never before it
    assign clear_active = (lc_state == LONG_COUNT_CLEAR_BIT);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            lc_state <= LC_IDLE;
        end else begin
            unique case (lc_state)
                LC_IDLE: begin
                    if (long_count_clear_cmd) begin
                        lc_state <= LONG_COUNT_CLEAR_BIT;
                    end
                end
                LONG_COUNT_CLEAR_BIT: begin
                    lc_state <= LC_DONE;
                end
                LC_DONE: begin
                    if (long_count_clear_cmd) begin
                        lc_state <= LONG_COUNT_CLEAR_BIT;
                    end
                end
                default: begin
                    lc_state <= LC_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            long_count_clear_cmd <= 1'b0;
        end else if (wr_stb && hit(reg_idx, IDX_CLEAR_CTRL)) begin
            long_count_clear_cmd <= wr_byte[BIT_CLEAR_CMD];
        end else if (long_count_clear_cmd) begin
            // Command is consumed in one cycle
            long_count_clear_cmd <= 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            long_count_clear_done <= 1'b0;
        end else if (clear_active) begin
            long_count_clear_done <= 1'b1;
        end else if (long_count_clear_cmd) begin
            // A fresh command hides the stale done flag
            long_count_clear_done <= 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            long_count <= RST_COUNT;
        end else if (clear_active) begin
            long_count <= RST_COUNT;
        end else if (wr_stb && hit(reg_idx, IDX_COUNT_LOW)) begin
            long_count[7:0] <= wr_byte;
        end else if (wr_stb && hit(reg_idx, IDX_COUNT_HIGH)) begin
            long_count[15:8] <= wr_byte;
        end else if (long_count_tick_i) begin
            long_count <= long_count + 16'h0001;
        end
    end

    // Advanced-feature page window
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            page_wr_o <= '0;
            page_rd_o <= 1'b0;
        end else begin
            page_wr_o.valid <= wr_stb && hit(reg_idx, IDX_PAGE_DATA) && page_write_enable;
            page_wr_o.page <= page_select;
            page_wr_o.data <= wr_byte;
            page_rd_o <= rd_stb && hit(reg_idx, IDX_PAGE_DATA) && page_read_enable;
        end
    end

    // Interrupt status, mask and line
    assign irq_event[IRQ_MACH_LOW] = |gated_event[7:0];
    assign irq_event[IRQ_MACH_HIGH] = |gated_event[MACHINES-1:8];
    assign irq_event[IRQ_CLEAR_DONE] = clear_active;
    assign irq_event[IRQ_BATCH] = step_count_batch_enable && step_count_valid_i;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_status <= RST_IRQ;
        end else if (rd_stb && hit(reg_idx, IDX_IRQ_STATUS)) begin
            // New events in the read cycle survive the clear
            irq_status <= irq_event;
        end else begin
            irq_status <= irq_status | irq_event;
        end
    end

    // Mask gates only the line; status still records every event
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_mask <= RST_IRQ;
        end else if (wr_stb && hit(reg_idx, IDX_IRQ_MASK)) begin
            irq_mask <= wr_byte[IRQ_W-1:0];
        end
    end

    // Registered line lags the status bit by one cycle
    assign irq_pending = |(irq_status & irq_mask);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_o <= 1'b0;
        end else begin
            irq_o <= irq_pending;
        end
    end

    // Configuration out
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cfg_o <= '0;
        end else begin
            cfg_o.machine_enable <= {machine_enable_high, machine_enable_low};
            cfg_o.step_count_batch_enable <= step_count_batch_enable;
            cfg_o.embedded_irq_latch_mode <= embedded_irq_latch_mode;
            cfg_o.page_write_enable <= page_write_enable;
            cfg_o.page_read_enable <= page_read_enable;
            cfg_o.page_select <= page_select;
        end
    end

    // Read mux
    always_comb begin
        next_rdata = 32'h0000_0000;
        unique case (1'b1)
            hit(reg_idx, IDX_PAGE_SEL): begin
                next_rdata[PAGE_SEL_LSB +: PAGE_SEL_W] = page_select;
            end
            hit(reg_idx, IDX_STATUS_LOW): begin
                next_rdata[7:0] = machine_status[7:0];
            end
            hit(reg_idx, IDX_STATUS_HIGH): begin
                next_rdata[7:0] = machine_status[15:8];
            end
            hit(reg_idx, IDX_PAGE_ACCESS): begin
                next_rdata[BIT_LATCH_MODE] = embedded_irq_latch_mode;
                next_rdata[BIT_PAGE_WRITE] = page_write_enable;
                next_rdata[BIT_PAGE_READ] = page_read_enable;
            end
            hit(reg_idx, IDX_BATCH_CFG): begin
                next_rdata[BIT_BATCH_EN] = step_count_batch_enable;
            end
            hit(reg_idx, IDX_ENABLE_LOW): begin
                next_rdata[7:0] = machine_enable_low;
            end
            hit(reg_idx, IDX_ENABLE_HIGH): begin
                next_rdata[7:0] = machine_enable_high;
            end
            hit(reg_idx, IDX_COUNT_LOW): begin
                next_rdata[7:0] = long_count[7:0];
            end
            hit(reg_idx, IDX_COUNT_HIGH): begin
                next_rdata[7:0] = long_count[15:8];
            end
            hit(reg_idx, IDX_CLEAR_CTRL): begin
                next_rdata[BIT_CLEAR_CMD] = long_count_clear_cmd;
                next_rdata[BIT_CLEAR_DONE] = long_count_clear_done;
            end
            hit(reg_idx, IDX_PAGE_DATA): begin
                // Disabled reads return zero
                next_rdata[7:0] = page_read_enable ? page_rdata_i : 8'h00;
            end
            hit(reg_idx, IDX_IRQ_STATUS): begin
                next_rdata[IRQ_W-1:0] = irq_status;
            end
            hit(reg_idx, IDX_IRQ_MASK): begin
                next_rdata[IRQ_W-1:0] = irq_mask;
            end
            default: begin
                next_rdata = 32'h0000_0000;
            end
        endcase
    end

    // Zero outside ack keeps stale reads off the bus
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_dat_o <= 32'h0000_0000;
        end else if (rd_stb) begin
            wb_dat_o <= next_rdata;
        end else begin
            wb_dat_o <= 32'h0000_0000;
        end
    end

endmodule

/* File: mmcr_regs_asserts.sv */
// Purpose: Port-level checks for the motion machine control register bank
// Assumes: cfg_o shows the register values one cycle late, as the design promises
// Notes: Bound into every mmcr_regs instance at the foot of this file
`timescale 1ns/1ps
module mmcr_regs_asserts
    import mmcr_pkg::*;
#(
    parameter int MACHINES = MMCR_MACHINES
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [MMCR_ADDR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic step_count_valid_i,
    input wire logic [15:0] step_count_i,
    input wire logic [7:0] page_rdata_i,
    input wire mmcr_cfg_t cfg_o,
    input wire mmcr_page_wr_t page_wr_o,
    input wire logic page_rd_o,
    input wire logic fifo_wr_o,
    input wire logic [15:0] fifo_data_o,
    input wire logic irq_o
);
    logic taken;
    logic [7:0] idx;
    assign taken = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    assign idx = wb_adr_i[9:2];
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    ack_next_cycle_a: assert property (taken |=> wb_ack_o)
        else $error("request not answered one cycle later");
    ack_has_cause_a: assert property (wb_ack_o |-> $past(taken) ##1 !wb_ack_o)
        else $error("ack without request or longer than one cycle");
    idle_data_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
        else $error("read data not zero outside ack");
    page_read_data_a: assert property (wb_ack_o && $past(!wb_we_i && idx == IDX_PAGE_DATA) |->
        wb_dat_o == (cfg_o.page_read_enable ? {24'h0, $past(page_rdata_i)} : 32'h0))
        else $error("page window read data wrong");
    page_read_pulse_a: assert property (page_rd_o ==
        ($past(taken && !wb_we_i && idx == IDX_PAGE_DATA) && cfg_o.page_read_enable))
        else $error("page read strobe wrong");
    page_write_gate_a: assert property (page_wr_o.valid ==
        ($past(taken && wb_we_i && wb_sel_i[0] && idx == IDX_PAGE_DATA) && cfg_o.page_write_enable))
        else $error("page write strobe wrong");
    page_write_target_a: assert property (page_wr_o.valid |-> page_wr_o.page == cfg_o.page_select
        && page_wr_o.data == $past(wb_dat_i[7:0]))
        else $error("page write goes to wrong page or data");
    batch_gate_a: assert property (fifo_wr_o == ($past(step_count_valid_i) && cfg_o.step_count_batch_enable))
        else $error("fifo write strobe wrong");
    batch_data_a: assert property (fifo_wr_o |-> fifo_data_o == $past(step_count_i))
        else $error("fifo data is not the step value");
    cfg_by_write_a: assert property (!$stable(cfg_o) && !$past(rst_i) |-> $past(taken && wb_we_i, 2))
        else $error("configuration changed without a write");

    cover property (page_wr_o.valid);
    cover property (page_rd_o);
    cover property (fifo_wr_o);
    cover property ($rose(irq_o));
endmodule

bind mmcr_regs mmcr_regs_asserts #(.MACHINES(MACHINES)) u_chk (.*);

/* File: tb.sv */
// Purpose: Self-checking bench for the motion machine control register bank
// Assumes: Outputs read right after an edge show the value sampled at that edge
// Notes: Register model kept as an int array in the bench
`timescale 1ns/1ps
`define CHK(a, b, s) begin tests_run++; if ((a) !== (b)) begin fails++; \
    $display("unexpected at %0t: %s got %h want %h", $time, s, a, b); end end
module tb;
    import mmcr_pkg::*;
    logic clk_i = 1'h0, rst_i = 1'h1, cyc = 1'h0, stb = 1'h0, we = 1'h0, sv = 1'h0, tick = 1'h0;
    logic ack, irq, prd_o, fw;
    logic [9:0] adr = 10'h0;
    logic [3:0] sel = 4'h0;
    logic [31:0] dat = 32'h0, rdat;
    logic [15:0] ev = 16'h0, sc = 16'h0, fd, en, e, n;
    logic [7:0] prd = 8'h00, q;
    mmcr_cfg_t cfg;
    mmcr_page_wr_t pw;
    int fails = 0, tests_run = 0, m[256], k, prc = 0;
    logic [15:0] pwq[$], fq[$], got;
    logic [7:0] rl[13] = '{8'h02, 8'h13, 8'h14, 8'h17, 8'h44, 8'h46, 8'h47, 8'h48, 8'h49, 8'h4A, 8'h60, 8'h61, 8'h7E};
    logic [7:0] wl[5] = '{8'h02, 8'h17, 8'h44, 8'h46, 8'h47};
    logic [7:0] mk[5] = '{8'h0F, 8'hE0, 8'h40, 8'hFF, 8'hFF};

    mmcr_regs #(.MACHINES(16)) dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .machine_event_i(ev), .long_count_tick_i(tick), .step_count_valid_i(sv), .step_count_i(sc),
        .page_rdata_i(prd), .cfg_o(cfg), .page_wr_o(pw), .page_rd_o(prd_o), .fifo_wr_o(fw),
        .fifo_data_o(fd), .irq_o(irq));

    initial begin
        forever #50 clk_i = ~clk_i;
    end

    // Strobes are one cycle wide, so catch them as they pass
    always @(posedge clk_i) begin
        if (pw.valid === 1'h1) pwq.push_back({pw.page, pw.data});
        if (fw === 1'h1) fq.push_back(fd);
        if (prd_o === 1'h1) prc++;
    end

    task automatic results();
        $display("comparisons %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask

    // Classic cycle: hold everything until ack is sampled, then idle one cycle
    task automatic bus(input logic w, input logic [7:0] i, input logic [7:0] d);
        int t;
        t = 0;
        {cyc, stb, we} <= {2'h3, w};
        adr <= {i, 2'h0};
        dat <= {24'h0, d};
        sel <= 4'hF;
        do begin
            @(posedge clk_i);
            t++;
        end while (ack !== 1'h1 && t < 20);
        q = rdat[7:0];
        {cyc, stb, we} <= 3'h0;
        if (ack !== 1'h1) begin
            fails++;
            results();
        end
        @(posedge clk_i);
    endtask

    task automatic rd(input logic [7:0] i, input logic [7:0] x, input string s);
        bus(1'h0, i, 8'h00);
        `CHK(q, x, s)
    endtask

    initial begin
        void'($urandom(87359));
        repeat (10) @(posedge clk_i);
        rst_i <= 1'h0;
        @(posedge clk_i);
        foreach (rl[i]) rd(rl[i], 8'h00, "reset value");
        `CHK(cfg, 24'h0, "cfg reset")
        $display("done: reset values");
        for (k = 0; k < 4; k++) begin
            foreach (wl[j]) begin
                m[wl[j]] = {24'h0, 8'($urandom()) & mk[j]};
                bus(1'h1, wl[j], m[wl[j]][7:0]);
            end
            foreach (wl[j]) rd(wl[j], m[wl[j]][7:0], "read back");
        end
        `CHK(cfg, {m[8'h47][7:0], m[8'h46][7:0], m[8'h44][6], m[8'h17][7:5], m[8'h02][3:0]}, "cfg")
        $display("done: read write");
        for (k = 0; k < 2; k++) begin
            bus(1'h1, 8'h17, k ? 8'h00 : 8'h60);
            e = 16'($urandom());
            prd <= e[15:8];
            bus(1'h1, 8'h50, e[7:0]);
            rd(8'h50, k ? 8'h00 : e[15:8], "page read");
            `CHK(pwq.size(), k ? 0 : 1, "page write count")
            `CHK(prc, 1, "page read count")
            if (pwq.size() > 0) begin
                got = pwq.pop_front();
                `CHK(got, {4'h0, m[8'h02][3:0], e[7:0]}, "page write")
            end
        end
        $display("done: page window");
        en = 16'($urandom());
        bus(1'h1, 8'h46, en[7:0]);
        bus(1'h1, 8'h47, en[15:8]);
        for (k = 0; k < 2; k++) begin
            // Unlatched holds the event level; latched sees only a one-cycle pulse
            bus(1'h1, 8'h17, k ? 8'h80 : 8'h00);
            e = 16'($urandom());
            ev <= e;
            @(posedge clk_i);
            if (k) ev <= 16'h0;
            repeat (2) begin
                rd(8'h13, e[7:0] & en[7:0], "status low");
                rd(8'h14, e[15:8] & en[15:8], "status high");
                ev <= 16'h0;
                e = 16'h0;
                @(posedge clk_i);
            end
        end
        $display("done: machine status");
        bus(1'h1, 8'h48, 8'hFF);
        bus(1'h1, 8'h49, 8'h00);
        n = 16'($urandom_range(2, 40));
        tick <= 1'h1;
        repeat (n) @(posedge clk_i);
        tick <= 1'h0;
        e = 16'h00FF + n;
        rd(8'h48, e[7:0], "count low");
        rd(8'h49, e[15:8], "count high");
        bus(1'h0, 8'h60, 8'h00);
        for (k = 0; k < 2; k++) begin
            bus(1'h1, 8'h61, k ? 8'h00 : 8'h04);
            bus(1'h1, 8'h48, 8'h5A);
            bus(1'h1, 8'h49, 8'hA5);
            bus(1'h1, 8'h4A, 8'h01);
            rd(8'h4A, 8'h02, "clear done");
            rd(8'h48, 8'h00, "cleared low");
            rd(8'h49, 8'h00, "cleared high");
            `CHK(irq, k ? 1'h0 : 1'h1, "irq level")
            rd(8'h60, 8'h04, "irq status");
            repeat (2) @(posedge clk_i);
            `CHK(irq, 1'h0, "irq after read")
        end
        $display("done: long counter");
        for (k = 0; k < 2; k++) begin
            bus(1'h1, 8'h44, k ? 8'h00 : 8'h40);
            e = 16'($urandom());
            {sv, sc} <= {1'h1, e};
            @(posedge clk_i);
            sv <= 1'h0;
            repeat (2) @(posedge clk_i);
            `CHK(fq.size(), k ? 0 : 1, "fifo count")
            if (fq.size() > 0) begin
                got = fq.pop_front();
                `CHK(got, e, "fifo data")
            end
        end
        $display("done: batching");
        results();
    end
endmodule
